// ==== rtl/line_asm_map.vh ====
`ifndef LINE_ASM_MAP_VH
`define LINE_ASM_MAP_VH

// unit identifiers answered on the serial bus
`define UNIT_ONE_ID      8'h40
`define UNIT_THREE_ID    8'h42
// command frame contents
`define CMD_WRITE        8'h57
`define CMD_STATUS       8'h53
`define AUX_NORMAL       8'h4E
`define CMD_LAST         6'h04
`define FRAME_LEN        6'h28
// response bytes
`define RSP_ACK          8'h41
`define RSP_NAK          8'h4E
`define RSP_COMPLETE     8'h43
`define RSP_ERROR        8'h45
// status frame
`define STAT_SECOND      8'h00
`define STAT_TIMEOUT     8'h0F
`define STAT_UNUSED      8'h30
`define STAT_LAST        3'h5
// stream codes
`define CH_EOL           8'h9B
`define CH_ESC           8'h1B
`define CH_FIRST_PRINT   7'h20
`define CH_GRAVE         7'h60
`define CH_LBRACE        7'h7B
`define CH_BLANK_FROM    7'h7D
`define CH_BLANK         7'h20
// escape codes, compared with bit 7 masked
`define ESC_DENS_165     7'h14
`define ESC_DENS_10      7'h0F
`define ESC_DENS_5       7'h0E
`define ESC_SHORT        7'h53
`define ESC_LONG         7'h4C
`define ESC_LPI6         7'h36
`define ESC_LPI8         7'h38
`define ESC_EURO_ON      7'h17
`define ESC_EURO_OFF     7'h18
// density encodings and line widths
`define DENS_5           2'h0
`define DENS_10          2'h1
`define DENS_165         2'h2
`define W_LONG_5         8'h28
`define W_LONG_10        8'h50
`define W_LONG_165       8'h84
`define W_SHORT_5        8'h20
`define W_SHORT_10       8'h40
`define W_SHORT_165      8'h69
`define CTR_5            8'h04
`define CTR_10           8'h08
`define CTR_165          8'h0D
// line buffer layout
`define FRAME_BASE       8'hC0
// register map
`define REG_CTRL         8'h00
`define REG_STATE        8'h04
`define REG_LINES        8'h08
`define CTRL_RESET       2'h3

`endif

// ==== rtl/line_buffer_ram.v ====
`timescale 1ns/1ps
`default_nettype none

// 256 x 8 store: line at the bottom, raw frame above it
module line_buffer_ram (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       we,
  input  wire [7:0] waddr,
  input  wire [7:0] wdata,
  input  wire [7:0] raddr,
  output reg  [7:0] rdata
);

  reg [7:0] mem [0:255];  // no reset on the array itself

  // write port
  always @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read, one cycle latency
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

`default_nettype wire

// ==== rtl/printer_line_assembler.v ====
// What this block does
// [R1] answer device identifiers 40 and 42
// [R2] write needs aux 4E, else negative acknowledge
// [R3] data frame holds exactly forty bytes
// [R4] append frames; end-of-line ends line, discards rest
// [R5] full width prints line, remainder continues
// [R6] print after acknowledge, before completion
// [R7] no paper returns error to write
// [R8] escape density codes select 16.5, 10, 5
// [R9] escape S short, L long widths
// [R10] short lines centered in long area
// [R11] escape 6 or 8 sets spacing
// [R12] settings persist; defaults 10, long, 6
// [R13] setting escapes only at line start
// [R14] unknown escapes dropped; repeated escapes stay armed
// [R15] escape code masked; escape byte exact
// [R16] default set: filter, blank, drop codes
// [R17] escape 17/18 toggle european glyphs anywhere
// [R18] status returns flags, 00, 0F, 30
// [R19] status resets settings and line buffer
// [R20] line handed out by request/done handshake
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "line_asm_map.vh"

module printer_line_assembler (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        rx_valid,
  input  wire        rx_cmd,
  input  wire [7:0]  rx_byte,
  output reg         tx_valid,
  output reg  [7:0]  tx_byte,
  input  wire        tx_ready,
  input  wire        paper_present,
  output reg         print_req,
  output reg  [7:0]  print_len,
  output reg  [7:0]  print_offset,
  output reg  [1:0]  print_density,
  output reg         print_lpi8,
  input  wire [7:0]  print_rd_addr,
  output wire [7:0]  print_rd_data,
  input  wire        print_done
);

  ////////////////////////////////////////////////////////////////////////
  // states, one-hot
  localparam [7:0] S_IDLE  = 8'h01;  // collecting command frame
  localparam [7:0] S_DATA  = 8'h02;  // collecting data frame
  localparam [7:0] S_TX    = 8'h04;  // holding a response byte
  localparam [7:0] S_RD    = 8'h08;  // fetching a frame byte
  localparam [7:0] S_CHAR  = 8'h10;  // interpreting a frame byte
  localparam [7:0] S_PRINT = 8'h20;  // mechanism busy with a line
  localparam [7:0] S_STAT  = 8'h40;  // sending status sequence
  localparam [7:0] S_DONE  = 8'h80;  // sending final byte

  reg [7:0]  state_q;      // current state
  reg [7:0]  ret_q;        // state after a response byte
  reg [5:0]  cnt_q;        // byte counter within a frame
  reg [7:0]  chk_q;        // running checksum
  reg [7:0]  dev_q;        // captured device identifier
  reg [7:0]  cmd_q;        // captured command
  reg [7:0]  command_aux_byte_one_q;  // captured first aux byte
  reg [5:0]  idx_q;        // frame byte being interpreted
  reg [7:0]  col_q;        // next free column in the line
  reg [7:0]  fin_q;        // final byte of a write
  reg [2:0]  k_q;          // status byte index
  reg        resume_q;     // more frame bytes after a wrap print
  reg        esc_q;        // escape armed
  reg [1:0]  dens_q;       // character density
  reg        long_q;       // long line width
  reg        lpi8_q;       // 8 lines per inch
  reg        euro_q;       // european glyphs enabled
  reg        cmd_err_q;    // command frame error seen
  reg        data_err_q;   // data frame error seen
  reg [1:0]  ctrl_q;       // per-identifier answer enables
  reg [15:0] lines_q;      // lines handed to the mechanism
  reg        wr_ph_q;      // write data phase pending
  reg [7:0]  wa_q;         // address of pending write

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // end-around carry sum used by the command, data and status frame checksums
  function [7:0] csum;
    input [7:0] a;
    input [7:0] b;
    reg   [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      csum = s[7:0] + {7'h00, s[8]};
    end
  endfunction

  // line width for density and width selection
  function [7:0] width_of;
    input [1:0] d;
    input       l;
    begin
      case (d)
        `DENS_5:   width_of = l ? `W_LONG_5 : `W_SHORT_5;
        `DENS_165: width_of = l ? `W_LONG_165 : `W_SHORT_165;
        default:   width_of = l ? `W_LONG_10 : `W_SHORT_10;
      endcase
    end
  endfunction

  // left margin that centres a short line
  function [7:0] center_of;
    input [1:0] d;
    begin
      case (d)
        `DENS_5:   center_of = `CTR_5;
        `DENS_165: center_of = `CTR_165;
        default:   center_of = `CTR_10;
      endcase
    end
  endfunction

  // {keep, stored code}; bit 7 already masked
  function [7:0] glyph_of;
    input [6:0] c;
    input       eu;
    begin
      if (c >= `CH_BLANK_FROM) begin
        glyph_of = {1'b1, `CH_BLANK};  // outside the glyph set
      end else if (eu) begin
        glyph_of = {1'b1, c};  // see [R17]
      end else if (c < `CH_FIRST_PRINT) begin
        glyph_of = {1'b0, c};  // see [R16]
      end else if (c == `CH_GRAVE || c == `CH_LBRACE) begin
        glyph_of = {1'b1, `CH_BLANK};  // see [R16]
      end else begin
        glyph_of = {1'b1, c};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode of the byte under interpretation
  wire [7:0] mem_rdata;                           // frame byte
  wire       is_eol   = mem_rdata == `CH_EOL;      // see [R4]
  wire       is_esc   = mem_rdata == `CH_ESC;      // see [R15]
  wire [6:0] code7    = mem_rdata[6:0];            // see [R15]
  wire [7:0] glyph    = glyph_of(code7, euro_q);
  wire       plain    = !is_eol && !esc_q && !is_esc && glyph[7];
  wire       col_zero = col_q == 8'h00;
  wire [7:0] col_next = col_q + 8'h01;
  wire [7:0] width    = width_of(dens_q, long_q);
  wire       last     = idx_q == (`FRAME_LEN - 6'h01);
  wire       id_ok    = (dev_q == `UNIT_ONE_ID && ctrl_q[0]) ||
                        (dev_q == `UNIT_THREE_ID && ctrl_q[1]);  // see [R1]
  wire       data_in  = rx_valid && !rx_cmd;

  // status byte sequence
  reg [7:0] stat_byte;
  always @* begin
    case (k_q)
      3'h0:    stat_byte = `RSP_COMPLETE;
      3'h1:    stat_byte = {6'h00, data_err_q, cmd_err_q};  // see [R18]
      3'h2:    stat_byte = `STAT_SECOND;                     // see [R18]
      3'h3:    stat_byte = `STAT_TIMEOUT;                    // see [R18]
      3'h4:    stat_byte = `STAT_UNUSED;                     // see [R18]
      default: stat_byte = chk_q;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer port steering
  reg       mem_we;     // write strobe
  reg [7:0] mem_waddr;  // write address
  reg [7:0] mem_wdata;  // write data
  reg [7:0] mem_raddr;  // read address

  // frame bytes land raw above the line; glyphs land at the column
  always @* begin
    mem_we    = 1'b0;
    mem_waddr = `FRAME_BASE + {2'h0, cnt_q};
    mem_wdata = rx_byte;
    mem_raddr = `FRAME_BASE + {2'h0, idx_q};
    if (state_q == S_DATA && data_in && cnt_q < `FRAME_LEN) begin
      mem_we = 1'b1;  // see [R3]
    end
    if (state_q == S_CHAR && plain) begin
      mem_we    = 1'b1;  // see [R4]
      mem_waddr = col_q;
      mem_wdata = {1'b0, glyph[6:0]};
    end
    if (state_q == S_PRINT) begin
      mem_raddr = print_rd_addr;  // mechanism owns the read port
    end
  end

  line_buffer_ram u_ram (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  // the mechanism reads the registered buffer output
  assign print_rd_data = mem_rdata;

  ////////////////////////////////////////////////////////////////////////
  // response and print launch helpers

  // hold a byte on the transmit port until taken
  task send;
    input [7:0] b;
    input [7:0] r;
    begin
      tx_valid <= 1'b1;
      tx_byte  <= b;
      ret_q    <= r;
      state_q  <= S_TX;
    end
  endtask

  // latch line geometry; spacing is sampled now, so a late change wins
  task launch;
    input [7:0] len;
    input       more;
    begin
      print_req     <= 1'b1;                          // see [R20]
      print_len     <= len;
      print_offset  <= long_q ? 8'h00 : center_of(dens_q);  // see [R10]
      print_density <= dens_q;
      print_lpi8    <= lpi8_q;                        // see [R11]
      resume_q      <= more;
      state_q       <= S_PRINT;                       // see [R6]
    end
  endtask

  // move on to the next frame byte or finish the write
  task advance;
    begin
      if (last) begin
        fin_q   <= `RSP_COMPLETE;
        state_q <= S_DONE;
      end else begin
        idx_q   <= idx_q + 6'h01;
        state_q <= S_RD;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // frame exchange and line assembly
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_IDLE;
      ret_q <= S_IDLE;
      cnt_q <= 6'h00;
      chk_q <= 8'h00;
      dev_q <= 8'h00;
      cmd_q <= 8'h00;
      command_aux_byte_one_q <= 8'h00;
      idx_q <= 6'h00;
      col_q <= 8'h00;
      fin_q <= `RSP_COMPLETE;
      k_q <= 3'h0;
      resume_q <= 1'b0;
      esc_q <= 1'b0;
      dens_q <= `DENS_10;  // see [R12]
      long_q <= 1'b1;      // see [R12]
      lpi8_q <= 1'b0;      // see [R12]
      euro_q <= 1'b0;
      cmd_err_q <= 1'b0;
      data_err_q <= 1'b0;
      lines_q <= 16'h0000;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
      print_req <= 1'b0;
      print_len <= 8'h00;
      print_offset <= 8'h00;
      print_density <= `DENS_10;
      print_lpi8 <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (!rx_cmd) begin
            cnt_q <= 6'h00;  // command line dropped: restart
          end else if (rx_valid) begin
            cnt_q <= cnt_q + 6'h01;
            chk_q <= (cnt_q == 6'h00) ? rx_byte : csum(chk_q, rx_byte);
            if (cnt_q == 6'h00) dev_q <= rx_byte;
            if (cnt_q == 6'h01) cmd_q <= rx_byte;
            if (cnt_q == 6'h02) command_aux_byte_one_q <= rx_byte;
            if (cnt_q == `CMD_LAST) begin
              cnt_q <= 6'h00;
              if (!id_ok) begin
                state_q <= S_IDLE;  // another unit's frame
              end else if (rx_byte != chk_q) begin
                cmd_err_q <= 1'b1;
                send(`RSP_NAK, S_IDLE);
              end else if (cmd_q == `CMD_WRITE &&
                           command_aux_byte_one_q == `AUX_NORMAL) begin
                send(`RSP_ACK, S_DATA);  // see [R2]
              end else if (cmd_q == `CMD_STATUS) begin
                k_q    <= 3'h0;
                dens_q <= `DENS_10;  // see [R19]
                long_q <= 1'b1;
                lpi8_q <= 1'b0;
                euro_q <= 1'b0;
                col_q  <= 8'h00;
                esc_q  <= 1'b0;
                send(`RSP_ACK, S_STAT);
              end else begin
                cmd_err_q <= 1'b1;
                send(`RSP_NAK, S_IDLE);  // see [R2]
              end
            end
          end
        end
        S_DATA: begin
          if (rx_valid && rx_cmd) begin
            cnt_q   <= 6'h00;  // host gave up on the data frame
            state_q <= S_IDLE;
          end else if (data_in && cnt_q < `FRAME_LEN) begin
            chk_q <= (cnt_q == 6'h00) ? rx_byte : csum(chk_q, rx_byte);
            cnt_q <= cnt_q + 6'h01;  // see [R3]
          end else if (data_in) begin
            cnt_q <= 6'h00;
            idx_q <= 6'h00;
            if (rx_byte != chk_q) begin
              data_err_q <= 1'b1;
              send(`RSP_NAK, S_IDLE);
            end else if (!paper_present) begin
              fin_q <= `RSP_ERROR;  // see [R7]
              send(`RSP_ACK, S_DONE);
            end else begin
              send(`RSP_ACK, S_RD);  // see [R6]
            end
          end
        end
        S_TX: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            state_q  <= ret_q;
          end
        end
        S_RD: begin
          state_q <= S_CHAR;  // read data valid next cycle
        end
        S_CHAR: begin
          if (is_eol) begin
            esc_q <= 1'b0;
            launch(col_q, 1'b0);  // see [R4]
          end else if (esc_q) begin
            if (!is_esc) begin
              esc_q <= 1'b0;  // see [R14]
              case (code7)
                `ESC_DENS_165: if (col_zero) dens_q <= `DENS_165;  // see [R8]
                `ESC_DENS_10:  if (col_zero) dens_q <= `DENS_10;   // see [R8]
                `ESC_DENS_5:   if (col_zero) dens_q <= `DENS_5;    // see [R13]
                `ESC_SHORT:    if (col_zero) long_q <= 1'b0;       // see [R9]
                `ESC_LONG:     if (col_zero) long_q <= 1'b1;       // see [R9]
                `ESC_LPI6:     if (col_zero) lpi8_q <= 1'b0;       // see [R11]
                `ESC_LPI8:     if (col_zero) lpi8_q <= 1'b1;       // see [R11]
                `ESC_EURO_ON:  euro_q <= 1'b1;                     // see [R17]
                `ESC_EURO_OFF: euro_q <= 1'b0;                     // see [R17]
                default:       esc_q <= 1'b0;                      // see [R14]
              endcase
            end
            advance;
          end else if (is_esc) begin
            esc_q <= 1'b1;
            advance;
          end else if (plain && col_next == width) begin
            col_q <= col_next;
            launch(width, !last);  // see [R5]
          end else begin
            if (plain) col_q <= col_next;
            advance;
          end
        end
        S_PRINT: begin
          if (print_done) begin
            print_req <= 1'b0;  // see [R20]
            col_q     <= 8'h00;
            lines_q   <= lines_q + 16'h0001;
            if (resume_q) begin
              idx_q   <= idx_q + 6'h01;  // see [R5]
              state_q <= S_RD;
            end else begin
              fin_q   <= `RSP_COMPLETE;
              state_q <= S_DONE;
            end
          end
        end
        S_STAT: begin
          k_q <= k_q + 3'h1;
          if (k_q == 3'h1) chk_q <= stat_byte;
          if (k_q > 3'h1 && k_q < `STAT_LAST) chk_q <= csum(chk_q, stat_byte);
          if (k_q == `STAT_LAST) begin
            cmd_err_q  <= 1'b0;  // flags are reported once
            data_err_q <= 1'b0;
            send(stat_byte, S_IDLE);
          end else begin
            send(stat_byte, S_STAT);
          end
        end
        S_DONE: begin
          send(fin_q, S_IDLE);  // see [R6]
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait, always okay
  wire ap = hsel && htrans[1] && hready;  // address phase taken

  // read data is settled at the address phase edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      wr_ph_q   <= 1'b0;
      wa_q      <= 8'h00;
      ctrl_q    <= `CTRL_RESET;
    end else begin
      hreadyout <= 1'b1;
      wr_ph_q   <= ap && hwrite;
      if (ap) wa_q <= haddr[7:0];
      if (ap && !hwrite) begin
        case (haddr[7:0])
          `REG_CTRL:  hrdata <= {30'h0000_0000, ctrl_q};
          `REG_STATE: hrdata <= {8'h00, state_q, col_q, data_err_q,
                                 cmd_err_q, paper_present, euro_q,
                                 lpi8_q, long_q, dens_q};
          `REG_LINES: hrdata <= {16'h0000, lines_q};
          default:    hrdata <= 32'h0000_0000;  // unmapped reads zero
        endcase
      end
      if (wr_ph_q && wa_q == `REG_CTRL) begin
        ctrl_q <= hwdata[1:0];  // steers identifier matching
      end
    end
  end

endmodule

`default_nettype wire

// ==== verif/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host at the far end of the frame link
module host_model (
  input  wire logic       hclk,
  output var  logic       rx_valid,
  output var  logic       rx_cmd,
  output var  logic [7:0] rx_byte,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output var  logic       tx_ready
);
  logic [8:0] sum;      // running end-around checksum
  int         slow = 2; // idle cycles before taking an answer, at least 1

  initial begin
    rx_valid = 1'b0;
    rx_cmd   = 1'b0;
    rx_byte  = 8'h00;
    tx_ready = 1'b0;
    sum      = 9'h000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one byte, then the inverse
  task send_byte(input logic c, input logic [7:0] b);
    @(posedge hclk);
    rx_cmd   <= c;
    rx_valid <= 1'b1;
    rx_byte  <= b;
    @(posedge hclk);
    rx_valid <= 1'b0;
    rx_byte  <= ~b;
    sum = {1'b0, sum[7:0]} + {1'b0, b};
    sum = {1'b0, sum[7:0]} + {8'h00, sum[8]};
  endtask

  // five byte command frame
  task send_cmd(input logic [7:0] dev, input logic [7:0] cmd,
                input logic [7:0] aux);
    sum = 9'h000;
    send_byte(1'b1, dev);
    send_byte(1'b1, cmd);
    send_byte(1'b1, aux);
    send_byte(1'b1, 8'h00);
    send_byte(1'b1, sum[7:0]);
    rx_cmd <= 1'b0;
  endtask

  // forty characters then the checksum
  task send_data(input logic [7:0] d [40]);
    int i;
    sum = 9'h000;
    for (i = 0; i < 40; i++) begin
      send_byte(1'b0, d[i]);
    end
    send_byte(1'b0, sum[7:0]);
  endtask

  // take one answer byte at the handshake edge
  task get_byte(output logic [7:0] b, output logic late);
    int n;
    repeat (slow) @(posedge hclk);
    tx_ready <= 1'b1;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (tx_valid !== 1'b1 && n < 3000);
    @(posedge hclk);
    b = tx_byte;
    late = (n >= 3000);
    tx_ready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verif/printer_line_assembler_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// print handshake and answer line checks
module line_asm_checker (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_ready,
  input wire logic       print_req,
  input wire logic       print_done,
  input wire logic [7:0] print_len,
  input wire logic [7:0] print_offset,
  input wire logic [1:0] print_density,
  input wire logic       print_lpi8,
  input wire logic [7:0] print_rd_data
);
  // one clock domain
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////
  print_quiet_a: assert property (print_req |-> !tx_valid)
    else $error("answer offered while a line prints");
  print_hold_a: assert property (print_req && !print_done |=> print_req
    && $stable(print_len) && $stable(print_offset)
    && $stable(print_density) && $stable(print_lpi8))
    else $error("line geometry moved before done");
  print_end_a: assert property (print_req && print_done |=> !print_req)
    else $error("request kept after done");
  center_off_a: assert property (print_req |-> print_offset == 8'h00
    || print_offset == (print_density == 2'h0 ? 8'h04 :
                        print_density == 2'h1 ? 8'h08 : 8'h0D))
    else $error("margin does not center a short line");
  width_cap_a: assert property (print_req |-> print_len <=
    (print_density == 2'h0 ? 8'h28 : print_density == 2'h1 ? 8'h50 : 8'h84))
    else $error("line longer than the widest setting");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid
    && $stable(tx_byte))
    else $error("answer byte dropped before taken");
  reset_dflt_a: assert property ($rose(hresetn) |->
    print_density == 2'h1 && !print_lpi8)
    else $error("settings not at power-on values");
  glyph_code_a: assert property (print_req && $past(print_req)
    |=> !print_rd_data[7])
    else $error("stored glyph has bit 7 set");
endmodule

bind printer_line_assembler line_asm_checker chk_u (.*);
`default_nettype wire

// ==== verif/test_printer_line_assembler.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_printer_line_assembler;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, paper;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, print_density, p_den;
  logic [2:0]  hsize;
  logic        rx_valid, rx_cmd, tx_valid, tx_ready, print_req, print_done;
  logic        print_lpi8, p_lpi;
  logic [7:0]  rx_byte, tx_byte, print_len, print_offset, print_rd_addr;
  logic [7:0]  print_rd_data, p_len, p_off, p_c0;
  logic [7:0]  fr [40];   // data frame under construction
  int          pcnt, nprint, bad_count, comparisons;

  printer_line_assembler dut_u (.*, .hready(hreadyout),
    .paper_present(paper));
  host_model host_u (.*);

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // print mechanism: latch geometry, done after 4 cycles
  always @(posedge hclk) begin
    if (print_req && !print_done) begin
      pcnt <= pcnt + 1;
      if (pcnt == 3) begin
        p_len <= print_len;
        p_off <= print_offset;
        p_den <= print_density;
        p_lpi <= print_lpi8;
        p_c0 <= print_rd_data;
        nprint <= nprint + 1;
        print_done <= 1'b1;
      end
    end else begin
      pcnt <= 0;
      print_done <= 1'b0;
    end
  end

  task give_verdict;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // a wait that ran out ends the run
  task stall(input logic hit);
    if (hit) begin
      bad_count++;
      $display("wrong value at %0t: no answer", $time);
      give_verdict;
    end
  endtask

  // one single word transfer; hready may hold either phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      if (n > 0) @(posedge hclk);
      n = (hreadyout === 1'b1) ? 0 : n + 1;
    end while (n > 0 && n < 50);
    r = hrdata;
    stall(n >= 50);
  endtask

  task rsp(input logic [7:0] exp);
    logic [7:0] b;
    logic       late;
    host_u.get_byte(b, late);
    stall(late);
    chk(32'(b), 32'(exp));
  endtask

  // write command plus frame; n of 40 means forty letters without end
  task wr(input logic [7:0] dev, input logic [63:0] w, input int n,
          input logic [7:0] fin);
    int i;
    for (i = 0; i < 40; i++) begin
      fr[i] = (n == 40) ? 8'h41 : (i < n) ? w[63-8*i -: 8] : 8'h9B;
    end
    host_u.send_cmd(dev, 8'h57, 8'h4E);
    rsp(8'h41);
    host_u.send_data(fr);
    rsp(8'h41);
    rsp(fin);
  endtask

  task pchk(input int len, input int off, input int den, input int lpi);
    chk(32'(p_len), 32'(len));
    chk(32'(p_off), 32'(off));
    chk(32'(p_den), 32'(den));
    chk(32'(p_lpi), 32'(lpi));
    chk(32'(p_c0), 32'h41);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task regs_check;
    logic [31:0] r;
    bus(1'b0, 8'h00, 32'h0, r);
    chk(r, 32'h3);
    chk(32'(hresp), 32'h0);
    bus(1'b1, 8'h04, 32'hffff_ffff, r);
    bus(1'b0, 8'h04, 32'h0, r);
    chk(r & 32'h3f, 32'h25);
    bus(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'h0);
  endtask

  // second identifier disabled: no answer
  task id_check;
    logic [31:0] r;
    logic        seen;
    bus(1'b1, 8'h00, 32'h1, r);
    host_u.send_cmd(8'h42, 8'h53, 8'h00);
    seen = 1'b0;
    repeat (40) begin
      @(posedge hclk);
      seen = seen | tx_valid;
    end
    chk(32'(seen), 32'h0);
    bus(1'b1, 8'h00, 32'h3, r);
  endtask

  // dropped code, blank glyph, text after end ignored
  task plain_line;
    wr(8'h40, 64'h0141_609b_5a00_0000, 5, 8'h43);
    chk(32'(nprint), 32'h1);
    pchk(2, 0, 1, 0);
  endtask

  // doubled escape, masked code, line-start gating
  task esc_line;
    wr(8'h42, 64'h1b1b_141b_531b_b841, 8, 8'h43);
    pchk(1, 13, 2, 1);
    wr(8'h42, 64'h411b_0e1b_4c9b_0000, 6, 8'h43);
    pchk(1, 13, 2, 1);
  endtask

  task bad_aux;
    host_u.send_cmd(8'h42, 8'h57, 8'h53);
    rsp(8'h4E);
  endtask

  // no paper: error even on a partial line
  task no_paper;
    int n0;
    n0 = nprint;
    paper <= 1'b0;
    wr(8'h42, 64'h0, 40, 8'h45);
    chk(32'(nprint), 32'(n0));
    paper <= 1'b1;
  endtask

  // status clears text and settings; then a wrap
  task status_reset;
    int n0;
    host_u.slow = 1;
    n0 = nprint;
    wr(8'h42, 64'h0, 40, 8'h43);
    host_u.send_cmd(8'h42, 8'h53, 8'h00);
    rsp(8'h41);
    rsp(8'h43);
    rsp(8'h01);
    rsp(8'h00);
    rsp(8'h0F);
    rsp(8'h30);
    rsp(8'h40);
    wr(8'h42, 64'h0, 40, 8'h43);
    chk(32'(nprint), 32'(n0));
    wr(8'h42, 64'h0, 40, 8'h43);
    chk(32'(nprint), 32'(n0 + 1));
    pchk(80, 0, 1, 0);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    paper = 1'b1;
    print_rd_addr = 8'h00;
    print_done = 1'b0;
    pcnt = 0;
    nprint = 0;
    bad_count = 0;
    comparisons = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    regs_check;
    id_check;
    plain_line;
    esc_line;
    bad_aux;
    no_paper;
    status_reset;
    give_verdict;
  end
endmodule
`default_nettype wire
